// ===== hw/modem_pkg.sv
package modem_pkg;
    // ==========================================
    // Mode word layout
    localparam int MODE_W = 4;
    localparam int DATA_EN_BIT = 0;
    localparam int HOOK_BIT = 1;
    localparam int ANSWER_BIT = 2;
    localparam int DIAL_BIT = 3;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [1:0] LAST_BIT_IDX = 2'h3;

    // ==========================================
    // Line levels
    localparam logic MARK_LEVEL = 1'b1;
    localparam logic IRQ_IDLE = 1'b1;

    // ==========================================
    // Host timing, system clock 200 MHz
    localparam int CLK_NS = 5;
    localparam int LINK_HALF_NS = 30;
    localparam int LINK_HALF_CYC = LINK_HALF_NS / CLK_NS;
    localparam int BIT_FRAMES = 6;
    localparam int FRAME_US = 16683;
    localparam int BIT_TIME_US = BIT_FRAMES * FRAME_US;
    localparam int BIT_CYC_DEF = (BIT_TIME_US * 1000) / CLK_NS;

    // ==========================================
    // Device timing, in link clock cycles
    localparam logic [3:0] RING_PULSE_CYC = 4'h4;

    // ==========================================
    // Buffer
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
endpackage

// ===== hw/modem_link_if.sv
`timescale 1ns/1ps
// Serial bus between host port and modem
interface modem_link_if;
    logic linkClk;
    logic cmdLine;
    logic motorLine;
    logic hostTxData;
    logic hostRxData;
    logic proceedLine;
    logic irqLine;

    modport device_mp (
        input linkClk,
        input cmdLine,
        input motorLine,
        input hostTxData,
        output hostRxData,
        output proceedLine,
        output irqLine
    );

    modport host_mp (
        output linkClk,
        output cmdLine,
        output motorLine,
        output hostTxData,
        input hostRxData,
        input proceedLine,
        input irqLine
    );
endinterface

// ===== hw/modem_device.sv
`timescale 1ns/1ps
module modem_device
    import modem_pkg::*;
(
    modem_link_if.device_mp link,
    input wire logic nrst,
    input wire logic phoneRxData,
    input wire logic remoteCarrierPresent,
    input wire logic ringDetect,
    output logic phoneTxData,
    output logic offHook,
    output logic answerMode,
    output logic dialEnable,
    output logic dataEnable
);
    import modem_pkg::*;

    // ==========================================
    // Input synchronisers
    localparam int SYNC_N = 6;
    localparam int S_CMD = 0;
    localparam int S_MOTOR = 1;
    localparam int S_HTX = 2;
    localparam int S_PRX = 3;
    localparam int S_CAR = 4;
    localparam int S_RING = 5;
    // Idle levels: carrier and ring idle low, all other lines idle high
    localparam logic [SYNC_N-1:0] SYNC_IDLE = 6'h0F;

    typedef enum logic [2:0] {
        RING_IDLE = 3'b001,
        RING_PULSE = 3'b010,
        RING_WAIT = 3'b100
    } ring_state_t;

    logic [SYNC_N-1:0] rawIn;
    logic [SYNC_N-1:0] meta_q;
    logic [SYNC_N-1:0] sync_q;
    logic motorPrev_q;
    logic [MODE_W-1:0] mode_q;
    logic [MODE_W-1:0] mode_d;
    logic motorFall;
    logic dialActive;
    logic hookLevel;
    logic txLevel;
    logic rxLevel;
    ring_state_t ring_q;
    ring_state_t ring_d;
    logic [3:0] ringCnt_q;
    logic [3:0] ringCnt_d;
    logic irqLevel;
    logic offHook_q;
    logic answer_q;
    logic dial_q;
    logic dataEn_q;
    logic phoneTx_q;
    logic hostRx_q;
    logic proceed_q;
    logic irq_q;

    // Pins arrive from other clocks; nothing reads meta_q but sync_q
    assign rawIn[S_CMD] = link.cmdLine;
    assign rawIn[S_MOTOR] = link.motorLine;
    assign rawIn[S_HTX] = link.hostTxData;
    assign rawIn[S_PRX] = phoneRxData;
    assign rawIn[S_CAR] = remoteCarrierPresent;
    assign rawIn[S_RING] = ringDetect;

    // Reset to each pin's idle level, so no false ring or carrier follows reset
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge link.linkClk or negedge nrst) begin
                if (!nrst) begin
                    meta_q[gi] <= SYNC_IDLE[gi];
                    sync_q[gi] <= SYNC_IDLE[gi];
                end else begin
                    meta_q[gi] <= rawIn[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    // ==========================================
    // Mode shift register
    // Only motor and command lines carry commands; nothing decodes frames
    assign motorFall = motorPrev_q & ~sync_q[S_MOTOR];

    // First bit shifted ends up in bit 0 after four edges
    // No end-of-command marker exists, so each edge updates the mode
    assign mode_d = motorFall ? {sync_q[S_CMD], mode_q[MODE_W-1:1]}
                              : mode_q;

    always_ff @(posedge link.linkClk or negedge nrst) begin
        if (!nrst) begin
            motorPrev_q <= 1'b1;
            mode_q <= MODE_RESET;
        end else begin
            motorPrev_q <= sync_q[S_MOTOR];
            mode_q <= mode_d;
        end
    end

    // ==========================================
    // Mode decode
    // Dialing hands hook control to the command line level
    assign dialActive = mode_q[DIAL_BIT];
    assign hookLevel = dialActive ? ~sync_q[S_CMD]
                                  : mode_q[HOOK_BIT];

    // Bits pass straight through unframed, so any baud rate well below the link clock works
    assign txLevel = mode_q[DATA_EN_BIT] ? sync_q[S_HTX] : MARK_LEVEL;
    assign rxLevel = mode_q[DATA_EN_BIT] ? sync_q[S_PRX] : MARK_LEVEL;

    // ==========================================
    // Ring pulse generator
    // One pulse per ring burst; hook never follows ringing
    always_comb begin
        ring_d = ring_q;
        ringCnt_d = ringCnt_q;
        case (ring_q)
            RING_IDLE: begin
                ringCnt_d = 4'h0;
                if (sync_q[S_RING]) begin
                    ring_d = RING_PULSE;
                end
            end
            RING_PULSE: begin
                ringCnt_d = ringCnt_q + 4'h1;
                if (ringCnt_q == RING_PULSE_CYC - 4'h1) begin
                    ring_d = RING_WAIT;
                end
            end
            RING_WAIT: begin
                ringCnt_d = 4'h0;
                if (!sync_q[S_RING]) begin
                    ring_d = RING_IDLE;
                end
            end
            default: begin
                ring_d = RING_IDLE;
                ringCnt_d = 4'h0;
            end
        endcase
    end

    // Interrupt line is active low while pulsing
    assign irqLevel = (ring_q == RING_PULSE) ? ~IRQ_IDLE : IRQ_IDLE;

    always_ff @(posedge link.linkClk or negedge nrst) begin
        if (!nrst) begin
            ring_q <= RING_IDLE;
            ringCnt_q <= 4'h0;
        end else begin
            ring_q <= ring_d;
            ringCnt_q <= ringCnt_d;
        end
    end

    // ==========================================
    // Output registers
    // Every pin and mode output comes from a flop
    always_ff @(posedge link.linkClk or negedge nrst) begin
        if (!nrst) begin
            offHook_q <= 1'b0;
            answer_q <= 1'b0;
            dial_q <= 1'b0;
            dataEn_q <= 1'b0;
            phoneTx_q <= MARK_LEVEL;
            hostRx_q <= MARK_LEVEL;
            proceed_q <= 1'b0;
            irq_q <= IRQ_IDLE;
        end else begin
            offHook_q <= hookLevel;
            answer_q <= mode_q[ANSWER_BIT];
            dial_q <= dialActive;
            dataEn_q <= mode_q[DATA_EN_BIT];
            phoneTx_q <= txLevel;
            hostRx_q <= rxLevel;
            proceed_q <= sync_q[S_CAR];
            irq_q <= irqLevel;
        end
    end

    // ==========================================
    // Port drive
    assign offHook = offHook_q;
    assign answerMode = answer_q;
    assign dialEnable = dial_q;
    assign dataEnable = dataEn_q;
    assign phoneTxData = phoneTx_q;
    assign link.hostRxData = hostRx_q;
    assign link.proceedLine = proceed_q;
    assign link.irqLine = irq_q;
endmodule

// ===== hw/modem_host.sv
`timescale 1ns/1ps
// Host end: clock maker, command shifter, status sampling
module modem_host
    import modem_pkg::*;
#(
    parameter int unsigned BIT_CYC = modem_pkg::BIT_CYC_DEF
) (
    modem_link_if.host_mp link,
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmdValid,
    input wire logic [modem_pkg::MODE_W-1:0] cmdMode,
    output logic cmdReady,
    output logic cmdBusy,
    input wire logic dialBreak,
    input wire logic txData,
    output logic rxData,
    output logic carrierSeen,
    output logic hostEdgeInputB
);
    import modem_pkg::*;

    typedef enum logic [2:0] {
        SH_IDLE = 3'b001,
        SH_SETUP = 3'b010,
        SH_LOW = 3'b100
    } shift_state_t;

    localparam logic [31:0] HALF_BIT = 32'(BIT_CYC / 2);
    localparam logic [3:0] LINK_LAST = 4'(LINK_HALF_CYC - 1);

    logic [3:0] div_q;
    logic linkClk_q;
    logic [MODE_W-1:0] buf_q [BUF_DEPTH];
    logic wrPtr_q;
    logic rdPtr_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic push;
    logic pop;
    logic ready_q;
    shift_state_t sh_q;
    shift_state_t sh_d;
    logic [31:0] timer_q;
    logic timerDone;
    logic [1:0] bitIdx_q;
    logic [MODE_W-1:0] word_q;
    logic cmd_q;
    logic cmd_d;
    logic bitStep;
    logic busy_q;
    logic motor_q;
    logic tx_q;
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic irqPrev_q;
    logic rx_q;
    logic car_q;
    logic edge_q;

    // ==========================================
    // Link clock divider; the device runs from this
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_q <= 4'h0;
            linkClk_q <= 1'b0;
        end else if (div_q == LINK_LAST) begin
            div_q <= 4'h0;
            linkClk_q <= ~linkClk_q;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // ==========================================
    // Two-entry command buffer; shifter stalls the drain
    assign push = cmdValid && ready_q;
    assign pop = (sh_q == SH_IDLE) && (cnt_q != 2'h0);
    assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            cnt_q <= 2'h0;
            ready_q <= 1'b1;
        end else begin
            wrPtr_q <= wrPtr_q ^ push;
            rdPtr_q <= rdPtr_q ^ pop;
            cnt_q <= cnt_d;
            ready_q <= (cnt_d != BUF_FULL);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            buf_q[wrPtr_q] <= cmdMode;
        end
    end

    // ==========================================
    // Command shifter: exactly four bits, bit 0 first, slow pace
    assign timerDone = (timer_q == HALF_BIT - 32'h1);

    always_comb begin
        sh_d = sh_q;
        case (sh_q)
            SH_IDLE: begin
                if (pop) begin
                    sh_d = SH_SETUP;
                end
            end
            SH_SETUP: begin
                if (timerDone) begin
                    sh_d = SH_LOW;
                end
            end
            SH_LOW: begin
                if (timerDone) begin
                    sh_d = (bitIdx_q == LAST_BIT_IDX) ? SH_IDLE : SH_SETUP;
                end
            end
            default: begin
                sh_d = SH_IDLE;
            end
        endcase
    end

    // First bit goes out at pop, each next bit as the shift clock rises; it then stands
    // through the whole low phase, since the far end samples late
    assign bitStep = (sh_q == SH_LOW) && timerDone;
    assign cmd_d = (sh_d == SH_IDLE) ? dialBreak :
                   pop ? buf_q[rdPtr_q][0] :
                   bitStep ? word_q[bitIdx_q + 2'h1] : cmd_q;

    // Command line follows dialBreak when idle, for pulse dialing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            sh_q <= SH_IDLE;
            timer_q <= 32'h0;
            bitIdx_q <= 2'h0;
            word_q <= MODE_RESET;
            cmd_q <= 1'b1;
            motor_q <= 1'b1;
            tx_q <= MARK_LEVEL;
        end else begin
            sh_q <= sh_d;
            busy_q <= (sh_d != SH_IDLE);
            tx_q <= txData;
            timer_q <= (sh_q == SH_IDLE || timerDone) ? 32'h0 : timer_q + 32'h1;
            if (pop) begin
                word_q <= buf_q[rdPtr_q];
                bitIdx_q <= 2'h0;
            end else if (sh_q == SH_LOW && timerDone) begin
                bitIdx_q <= bitIdx_q + 2'h1;
            end
            cmd_q <= cmd_d;
            motor_q <= (sh_d != SH_LOW);
        end
    end

    // ==========================================
    // Status sampling; edge detect reads the second stage only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 3'h7;
            sync_q <= 3'h7;
            irqPrev_q <= IRQ_IDLE;
            rx_q <= MARK_LEVEL;
            car_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            meta_q <= {link.irqLine, link.proceedLine, link.hostRxData};
            sync_q <= meta_q;
            irqPrev_q <= sync_q[2];
            rx_q <= sync_q[0];
            car_q <= sync_q[1];
            edge_q <= irqPrev_q & ~sync_q[2];
        end
    end

    // ==========================================
    // Port drive
    assign link.linkClk = linkClk_q;
    assign link.cmdLine = cmd_q;
    assign link.motorLine = motor_q;
    assign link.hostTxData = tx_q;
    assign cmdReady = ready_q;
    assign cmdBusy = busy_q;
    assign rxData = rx_q;
    assign carrierSeen = car_q;
    assign hostEdgeInputB = edge_q;
endmodule

// ===== dv/modem_link_asserts.sv
`timescale 1ns/1ps
// ==========================================
// Link checker, linkClk domain
module modem_link_asserts (
    input wire logic linkClk,
    input wire logic nrst,
    input wire logic cmdLine,
    input wire logic motorLine,
    input wire logic hostRxData,
    input wire logic irqLine
);
    logic m1_q, m2_q, m3_q, c1_q, c2_q;
    logic [3:0] mode_q;
    logic [3:0] mode_d;
    logic [3:0] settle_q;
    wire logic shiftNow = m3_q & ~m2_q;
    // Shadow of the device mode; settle count hides sync skew
    assign mode_d = shiftNow ? {c2_q, mode_q[3:1]} : mode_q;
    always_ff @(posedge linkClk or negedge nrst) begin
        if (!nrst) begin
            {m1_q, m2_q, m3_q, c1_q, c2_q} <= 5'h1F;
            mode_q <= 4'h0;
            settle_q <= 4'h0;
        end else begin
            {m1_q, m2_q, m3_q} <= {motorLine, m1_q, m2_q};
            {c1_q, c2_q} <= {cmdLine, c1_q};
            mode_q <= mode_d;
            settle_q <= shiftNow ? 4'h0 : settle_q + {3'h0, settle_q != 4'hF};
        end
    end

    default clocking @(posedge linkClk); endclocking
    default disable iff (!nrst);

    // ==========================================
    // Assertions
    a_irq_pulse_len: assert property ($fell(irqLine) |-> (!irqLine)[*4] ##1 irqLine)
        else $error("ring pulse length wrong");
    a_irq_rearm_gap: assert property ($rose(irqLine) |-> irqLine[*2])
        else $error("ring pulse restarted at once");
    a_rx_mark_idle: assert property ((settle_q > 4'h5 && !mode_q[0]) |-> hostRxData)
        else $error("data passed while disabled");
    a_cmd_hold_low: assert property ((!motorLine && !$past(motorLine)) |-> $stable(cmdLine))
        else $error("command bit moved during shift clock low");
    a_cmd_setup_bit: assert property ($fell(motorLine) |-> cmdLine == $past(cmdLine, 3))
        else $error("command bit not settled before shift edge");
    a_low_phase_min: assert property ($fell(motorLine) |-> (!motorLine)[*8])
        else $error("shift clock low phase too short");
    a_high_phase_min: assert property ($rose(motorLine) |-> motorLine[*8])
        else $error("shift clock high phase too short");
    a_low_phase_max: assert property ($fell(motorLine) |-> ##[1:40] motorLine)
        else $error("shift clock stuck low");

    // Main scenarios
    cover property (mode_q == 4'hA);
    cover property (mode_q == 4'h7);
    cover property ($fell(irqLine));
    cover property ($fell(hostRxData) && mode_q[0]);
endmodule

// ===== dv/modem_mode_shift_control_tb.sv
`timescale 1ns/1ps
module modem_mode_shift_control_tb;
    import modem_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic nrstDev = 1'b0;
    logic cmdValid = 1'b0;
    logic dialBreak = 1'b1;
    logic txData = 1'b1;
    logic phoneRxData = 1'b1;
    logic remoteCarrierPresent = 1'b0;
    logic ringDetect = 1'b0;
    logic [3:0] cmdMode = 4'h0;
    logic cmdReady, cmdBusy, rxData, carrierSeen, hostEdgeInputB;
    logic phoneTxData, offHook, answerMode, dialEnable, dataEnable;
    int failures = 0;
    int cmpCount = 0;

    modem_link_if lnk();
    // Short bit time keeps the run small; still 10 link clocks per half bit
    modem_host #(.BIT_CYC(240)) modem_host_i (.link(lnk), .clk_sys, .nrst, .cmdValid,
        .cmdMode, .cmdReady, .cmdBusy, .dialBreak, .txData, .rxData, .carrierSeen,
        .hostEdgeInputB);
    modem_device modem_device_i (.link(lnk), .nrst(nrstDev), .phoneRxData,
        .remoteCarrierPresent, .ringDetect, .phoneTxData, .offHook, .answerMode,
        .dialEnable, .dataEnable);
    modem_link_asserts modem_link_asserts_i (.linkClk(lnk.linkClk), .nrst(nrstDev),
        .cmdLine(lnk.cmdLine), .motorLine(lnk.motorLine), .hostRxData(lnk.hostRxData),
        .irqLine(lnk.irqLine));

    always #2.5 clk_sys = ~clk_sys;

    // ==========================================
    // Helpers
    task automatic tick(input int n = 1);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("Counts: %0d compares, %0d failures", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Idle must last a while, as busy dips briefly between queued words
    task automatic wait_idle;
        int idle = 0;
        for (int i = 0; i < 20000 && idle < 10; i++) begin
            tick();
            idle = (cmdBusy === 1'b0) ? idle + 1 : 0;
        end
        if (idle < 10) begin
            failures++;
            test_done();
        end else begin
            tick(130);
        end
    endtask

    task automatic send(input logic [3:0] m);
        cmdMode = m;
        cmdValid = 1'b1;
        tick();
        cmdValid = 1'b0;
        wait_idle();
    endtask

    // Dial mode hands hook control to the idle command level
    task automatic chk_mode(input logic [3:0] m);
        chk({dialEnable, answerMode, offHook, dataEnable},
            {m[3], m[2], m[3] ? ~dialBreak : m[1], m[0]});
    endtask

    // ==========================================
    // Scenarios
    task automatic test_modes;
        logic [3:0] codes [6] = '{4'h0, 4'h3, 4'h7, 4'h2, 4'h6, 4'hA};
        chk_mode(4'h0);
        foreach (codes[i]) begin
            send(codes[i]);
            chk_mode(codes[i]);
        end
        $display("test modes done");
    endtask

    task automatic test_dial;
        for (int p = 0; p < 3; p++) begin
            dialBreak = 1'b0;
            tick(60);
            chk({2'h0, dialEnable, offHook}, 4'h3);
            dialBreak = 1'b1;
            tick(60);
            chk({2'h0, dialEnable, offHook}, 4'h2);
        end
        send(4'h0);
        chk_mode(4'h0);
        $display("test dial done");
    endtask

    task automatic test_data;
        send(4'h3);
        for (int i = 0; i < 4; i++) begin
            txData = i[0];
            phoneRxData = ~i[0];
            tick(130);
            chk({2'h0, phoneTxData, rxData}, {2'h0, i[0], ~i[0]});
        end
        send(4'h2);
        txData = 1'b0;
        phoneRxData = 1'b0;
        tick(130);
        chk({2'h0, phoneTxData, rxData}, 4'h3);
        txData = 1'b1;
        phoneRxData = 1'b1;
        send(4'h0);
        $display("test data done");
    endtask

    task automatic test_carrier;
        for (int i = 0; i < 2; i++) begin
            remoteCarrierPresent = ~i[0];
            tick(130);
            chk({2'h0, lnk.proceedLine, carrierSeen}, {2'h0, ~i[0], ~i[0]});
        end
        $display("test carrier done");
    endtask

    task automatic test_ring;
        int edges = 0;
        for (int r = 0; r < 3; r++) begin
            ringDetect = 1'b1;
            for (int i = 0; i < 200; i++) begin
                tick();
                if (hostEdgeInputB === 1'b1) edges++;
            end
            ringDetect = 1'b0;
            tick(100);
        end
        chk(edges[3:0], 4'h3);
        chk({3'h0, offHook}, 4'h0);
        send(4'h7);
        chk_mode(4'h7);
        send(4'h0);
        $display("test ring done");
    endtask

    // Fill the two-entry buffer, get refused, then drain
    task automatic test_buffer;
        logic [3:0] w [3] = '{4'h3, 4'h7, 4'h6};
        logic rdy;
        int n = 0;
        cmdValid = 1'b1;
        for (int i = 0; i < 50 && n < 3; i++) begin
            cmdMode = w[n];
            rdy = cmdReady;
            tick();
            if (rdy === 1'b1) n++;
        end
        chk(n[3:0], 4'h3);
        cmdMode = 4'hA;
        tick();
        chk({3'h0, cmdReady}, 4'h0);
        tick(20);
        cmdValid = 1'b0;
        wait_idle();
        chk_mode(4'h6);
        $display("test buffer done");
    endtask

    initial begin
        tick(5);
        nrst = 1'b1;
        tick(40);
        nrstDev = 1'b1;
        tick(60);
        test_modes();
        test_dial();
        test_data();
        test_carrier();
        test_ring();
        test_buffer();
        test_done();
    end
endmodule
